// >>> verilog/tac_defs.svh
/*
 * Sequencer constants: times, cycle counts, register offsets, fields.
 * Assumes a 10 ns system clock; included by its bare name.
 */
`ifndef TAC_DEFS_SVH
`define TAC_DEFS_SVH

// Clock period and fixed times in nanoseconds
`define TAC_CLK_NS 10
`define TAC_T_OVH_HOST_NS 2125
`define TAC_T_OVH_REF_NS 2625
`define TAC_T_OVH_XY_NS 2500
`define TAC_T_OVH_XYZ_NS 4750
`define TAC_T_CONV_FIX_NS 4400
// Least times round up to whole cycles
`define TAC_CYC(ns) (((ns) + `TAC_CLK_NS - 1) / `TAC_CLK_NS)
`define TAC_OVH_HOST_CYC `TAC_CYC(`TAC_T_OVH_HOST_NS)
`define TAC_OVH_REF_CYC `TAC_CYC(`TAC_T_OVH_REF_NS)
`define TAC_OVH_XY_CYC `TAC_CYC(`TAC_T_OVH_XY_NS)
`define TAC_OVH_XYZ_CYC `TAC_CYC(`TAC_T_OVH_XYZ_NS)
`define TAC_CONV_FIX_CYC `TAC_CYC(`TAC_T_CONV_FIX_NS)

// Analog ratios and oscillator margin
`define TAC_BIAS_RATIO 82
`define TAC_BAT1_DIV 4
`define TAC_BAT2_DIV 2
`define TAC_OSC_MARGIN_PCT 12
`define TAC_RESULT_COUNT 10

// Host register offsets (byte addresses)
`define TAC_REG_CMD 8'h00
`define TAC_REG_STATUS 8'h04
`define TAC_REG_IRQ_STATUS 8'h08
`define TAC_REG_IRQ_CLEAR 8'h0C
`define TAC_REG_IRQ_ENABLE 8'h10
`define TAC_REG_WAIT_NOM 8'h14
`define TAC_REG_SETTLE 8'h18
`define TAC_REG_RD_IDX 8'h1C
`define TAC_REG_RD_DATA 8'h20
// Command register field positions
`define TAC_CMD_OP_MSB 4
`define TAC_CMD_TIMER_BIT 8
// Interrupt bit positions
`define TAC_IRQ_PEN_DOWN 0
`define TAC_IRQ_RESULT 1
`define TAC_IRQ_REFUSED 2
`define TAC_IRQ_PEN_UP 3
`define TAC_IRQ_W 4

`endif

// >>> verilog/tac_pkg.sv
/*
 * Types shared by both ends of the conversion sequencer link.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tac_pkg;
    typedef enum logic [4:0] {
        OP_NONE, OP_SCAN_X, OP_SCAN_Y, OP_SCAN_Z, OP_SCAN_XY, OP_SCAN_XYZ,
        OP_DRIVE_X, OP_DRIVE_Y, OP_DRIVE_Z, OP_CONV_X, OP_CONV_Y, OP_CONV_Z,
        OP_TEMPERATURE_READING_ONE, OP_TEMPERATURE_READING_TWO, OP_BAT1, OP_BAT2, OP_AUXILIARY_INPUT_ONE, OP_AUXILIARY_INPUT_TWO
    } tac_op_t;
    typedef enum logic [3:0] {
        CH_X, CH_Y, CH_Z1, CH_Z2, CH_T1, CH_T2, CH_B1, CH_B2, CH_A1, CH_A2
    } tac_chan_t;
    typedef enum logic [1:0] {RES_8, RES_10, RES_12} tac_res_t;
    typedef enum logic [2:0] {DS_IDLE, DS_OVH, DS_SETTLE, DS_CONV, DS_STORE} tac_dev_state_t;
    typedef enum logic [1:0] {HS_IDLE, HS_SETTLE, HS_WAIT} tac_host_state_t;
endpackage

// >>> verilog/tac_link_if.sv
/*
 * Link between the converter sequencer and its host controller.
 * Assumes both ends run on the same clock; the bench joins them.
 */
`timescale 1ns/1ps
`default_nettype none
interface tac_link_if;
    logic cmd_valid;
    tac_pkg::tac_op_t cmd_op;
    logic [3:0] rd_idx;
    logic [15:0] rd_data;
    logic pen_touch_irq_n;
    logic data_available_n;
    modport dev (input cmd_valid, cmd_op, rd_idx,
                 output rd_data, pen_touch_irq_n, data_available_n);
    modport host (output cmd_valid, cmd_op, rd_idx,
                  input rd_data, pen_touch_irq_n, data_available_n);
endinterface
`default_nettype wire

// >>> verilog/tac_timer.sv
/*
 * Loadable down counter giving a one-cycle done pulse.
 * Assumes the loader holds no load while it waits for done.
 */
`timescale 1ns/1ps
`default_nettype none
module tac_timer #(
    parameter int W = 20
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic done
);
    logic [W-1:0] cnt_q;

    if (W < 2) begin : g_bad_width
        $error("tac_timer width too small");
    end

    // A zero load still takes one cycle so done always fires
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
            done <= 1'b0;
        end else if (ce) begin
            if (load) begin
                cnt_q <= (value == '0) ? W'(1) : value;
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - W'(1);
            end
            done <= !load && (cnt_q == W'(1));
        end
    end
endmodule // tac_timer
`default_nettype wire

// >>> verilog/tac_device.sv
/*
 * Device end: pen detect, sequencing, timing, results, analog switches.
 * Assumes conv_data is on this clock and valid at each conversion end;
 * touch_sense is an asynchronous pin.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tac_defs.svh"

// What this block does
// - Pull pen interrupt low while panel touched.
// - Host command picks scan; device runs it.
// - Host watches status or waits conversion time.
// - Fixed wait lengthened by twelve percent.
// - Host drives panel, settles, then requests conversion.
// - Host-controlled conversion: 2.125us, settle, averaging.
// - First temperature: diode at base bias.
// - Second temperature: diode at 82x bias.
// - Battery one divided by four, two by two.
// - Divider powered only while battery sampled.
// - Reference measurement: 2.625us, reference delay, averaging.
// - On-demand reference powered per reference measurement.
// - Auxiliary inputs sequenced like battery, no divider.
// - Data-available falls when results stored.
// - Results right-justified, upper bits zero.
// - XY scan: 2.5us, settle plus pre-sense delay, averaging.
module tac_device #(
    parameter int TW = 20
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    tac_link_if.dev link,
    input wire logic touch_sense,
    input wire logic [11:0] conv_data,
    input wire tac_pkg::tac_res_t res_sel,
    input wire logic [2:0] avg_log2,
    input wire logic [15:0] settle_cyc,
    input wire logic [15:0] pre_sense_cyc,
    input wire logic [15:0] ref_delay_cyc,
    input wire logic ref_on_demand,
    input wire logic [7:0] conv_clk_div,
    output logic x_drive,
    output logic y_drive,
    output logic z_drive,
    output logic [3:0] mux_sel,
    output logic sampling,
    output logic bat1_div_en,
    output logic bat2_div_en,
    output logic ref_power,
    output logic bias_x82,
    output logic busy
);
    import tac_pkg::*;

    tac_dev_state_t st_q;
    tac_op_t op_q;
    tac_chan_t chan_q;
    logic touch_s1_q, touch_s2_q;
    logic [4:0] avg_left_q;
    logic [16:0] acc_q;
    logic [15:0] res_q [`TAC_RESULT_COUNT];
    logic hold_x_q, hold_y_q, hold_z_q;
    logic tmr_load, tmr_done, take, more;
    logic [TW-1:0] tmr_val, conv_cyc;
    logic [3:0] nbits;
    logic [11:0] sample, avg_res;

    if (TW < 17) begin : g_bad_tw
        $error("tac_device timer width too small");
    end

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    function automatic logic is_ref(input tac_chan_t ch);
        return ch inside {CH_T1, CH_T2, CH_B1, CH_B2, CH_A1, CH_A2};
    endfunction

    function automatic tac_chan_t first_chan(input tac_op_t op);
        unique case (op)
            OP_SCAN_X, OP_CONV_X: return CH_X;
            OP_SCAN_Z, OP_CONV_Z: return CH_Z1;
            OP_TEMPERATURE_READING_ONE: return CH_T1;
            OP_TEMPERATURE_READING_TWO: return CH_T2;
            OP_BAT1: return CH_B1;
            OP_BAT2: return CH_B2;
            OP_AUXILIARY_INPUT_ONE: return CH_A1;
            OP_AUXILIARY_INPUT_TWO: return CH_A2;
            default: return CH_Y;
        endcase
    endfunction

    // XY and XYZ scans run Y first, then X; XYZ then takes both pressure readings
    function automatic logic has_next(input tac_op_t op, input tac_chan_t ch);
        return (ch == CH_Y && (op == OP_SCAN_XY || op == OP_SCAN_XYZ))
            || (ch == CH_X && op == OP_SCAN_XYZ) || (ch == CH_Z1);
    endfunction

    function automatic tac_chan_t next_chan(input tac_chan_t ch);
        unique case (ch)
            CH_Y: return CH_X;
            CH_X: return CH_Z1;
            default: return CH_Z2;
        endcase
    endfunction

    // Settling before each step; Z2 shares the Z1 settle
    function automatic logic [TW-1:0] settle_for(input tac_op_t op, input tac_chan_t ch);
        if (is_ref(ch)) begin
            return TW'(ref_delay_cyc);
        end else if (op inside {OP_CONV_X, OP_CONV_Y, OP_CONV_Z} || ch == CH_Z2) begin
            return '0;
        end else if (op == OP_SCAN_XY || op == OP_SCAN_XYZ) begin
            return TW'(settle_cyc) + TW'(pre_sense_cyc);
        end
        return TW'(settle_cyc);
    endfunction

    function automatic logic [TW-1:0] overhead(input tac_op_t op);
        unique case (op)
            OP_SCAN_XY: return TW'(`TAC_OVH_XY_CYC);
            OP_SCAN_XYZ: return TW'(`TAC_OVH_XYZ_CYC);
            OP_TEMPERATURE_READING_ONE, OP_TEMPERATURE_READING_TWO, OP_BAT1, OP_BAT2, OP_AUXILIARY_INPUT_ONE, OP_AUXILIARY_INPUT_TWO:
                return TW'(`TAC_OVH_REF_CYC);
            default: return TW'(`TAC_OVH_HOST_CYC);
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Conversion arithmetic

    // Bits per conversion and the coarser converter word
    always_comb begin
        nbits = 4'd12;
        sample = conv_data;
        if (res_sel == RES_8) begin
            nbits = 4'd8;
            sample = {4'h0, conv_data[11:4]};
        end else if (res_sel == RES_10) begin
            nbits = 4'd10;
            sample = {2'h0, conv_data[11:2]};
        end
        conv_cyc = TW'(nbits) * TW'(conv_clk_div) + TW'(`TAC_CONV_FIX_CYC);
        avg_res = 12'((acc_q + 17'(sample)) >> avg_log2);
    end

    assign take = (st_q == DS_IDLE) && link.cmd_valid
        && (link.cmd_op inside {[OP_SCAN_X:OP_SCAN_XYZ], [OP_CONV_X:OP_AUXILIARY_INPUT_TWO]});
    assign more = has_next(op_q, chan_q);

    // Timer reload at each phase boundary
    always_comb begin
        tmr_load = 1'b0;
        tmr_val = '0;
        if (take) begin
            tmr_load = 1'b1;
            tmr_val = overhead(link.cmd_op);
        end else if (st_q == DS_OVH && tmr_done) begin
            tmr_load = 1'b1;
            tmr_val = settle_for(op_q, chan_q);
        end else if ((st_q == DS_SETTLE || st_q == DS_CONV) && tmr_done
                     && !(st_q == DS_CONV && avg_left_q == 5'd1)) begin
            tmr_load = 1'b1;
            tmr_val = conv_cyc;
        end else if (st_q == DS_STORE && more) begin
            tmr_load = 1'b1;
            tmr_val = settle_for(op_q, next_chan(chan_q));
        end
    end

    tac_timer #(.W(TW)) u_timer (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .load(tmr_load),
        .value(tmr_val),
        .done(tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    // Commands arriving while busy are ignored; the host paces itself
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= DS_IDLE;
            op_q <= OP_NONE;
            chan_q <= CH_X;
            avg_left_q <= 5'd1;
            acc_q <= '0;
        end else if (ce) begin
            unique case (st_q)
                DS_IDLE: if (take) begin
                    op_q <= link.cmd_op;
                    chan_q <= first_chan(link.cmd_op);
                    st_q <= DS_OVH;
                end
                DS_OVH: if (tmr_done) begin
                    st_q <= DS_SETTLE;
                end
                DS_SETTLE: if (tmr_done) begin
                    avg_left_q <= 5'd1 << avg_log2;
                    acc_q <= '0;
                    st_q <= DS_CONV;
                end
                DS_CONV: if (tmr_done) begin
                    acc_q <= acc_q + 17'(sample);
                    avg_left_q <= avg_left_q - 5'd1;
                    if (avg_left_q == 5'd1) begin
                        st_q <= DS_STORE;
                    end
                end
                DS_STORE: begin
                    st_q <= more ? DS_SETTLE : DS_IDLE;
                    if (more) begin
                        chan_q <= next_chan(chan_q);
                    end
                end
            endcase
        end
    end

    // Result store, right-justified with zero upper bits
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < `TAC_RESULT_COUNT; i++) begin
                res_q[i] <= 16'h0000;
            end
            link.rd_data <= 16'h0000;
        end else if (ce) begin
            if (st_q == DS_CONV && tmr_done && avg_left_q == 5'd1) begin
                res_q[chan_q] <= {4'h0, avg_res};
            end
            link.rd_data <= (link.rd_idx < 4'(`TAC_RESULT_COUNT))
                ? res_q[link.rd_idx] : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pen detect and completion flag

    // Pin passes two flops before use
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            touch_s1_q <= 1'b0;
            touch_s2_q <= 1'b0;
            link.pen_touch_irq_n <= 1'b1;
            link.data_available_n <= 1'b1;
            busy <= 1'b0;
        end else if (ce) begin
            touch_s1_q <= touch_sense;
            touch_s2_q <= touch_s1_q;
            link.pen_touch_irq_n <= !touch_s2_q;
            busy <= (st_q != DS_IDLE) || take;
            if (take) begin
                link.data_available_n <= 1'b1;
            end else if (st_q == DS_STORE && !more) begin
                link.data_available_n <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Analog switches

    // Drive commands hold drivers until the next command of any kind
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_x_q <= 1'b0;
            hold_y_q <= 1'b0;
            hold_z_q <= 1'b0;
        end else if (ce && st_q == DS_IDLE && link.cmd_valid) begin
            hold_x_q <= link.cmd_op == OP_DRIVE_X;
            hold_y_q <= link.cmd_op == OP_DRIVE_Y;
            hold_z_q <= link.cmd_op == OP_DRIVE_Z;
        end
    end

    // Divider only on while needed, reference too when ref_on_demand is set, to save power
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            x_drive <= 1'b0;
            y_drive <= 1'b0;
            z_drive <= 1'b0;
            mux_sel <= 4'h0;
            sampling <= 1'b0;
            bat1_div_en <= 1'b0;
            bat2_div_en <= 1'b0;
            ref_power <= 1'b0;
            bias_x82 <= 1'b0;
        end else if (ce) begin
            x_drive <= (st_q != DS_IDLE) ? (chan_q == CH_X) : hold_x_q;
            y_drive <= (st_q != DS_IDLE) ? (chan_q == CH_Y) : hold_y_q;
            z_drive <= (st_q != DS_IDLE) ? (chan_q inside {CH_Z1, CH_Z2}) : hold_z_q;
            mux_sel <= chan_q;
            sampling <= st_q == DS_CONV;
            bat1_div_en <= st_q == DS_CONV && chan_q == CH_B1;
            bat2_div_en <= st_q == DS_CONV && chan_q == CH_B2;
            ref_power <= !ref_on_demand
                || (st_q != DS_IDLE && is_ref(chan_q));
            bias_x82 <= st_q != DS_IDLE && chan_q == CH_T2;
        end
    end
endmodule // tac_device
`default_nettype wire

// >>> verilog/tac_host.sv
/*
 * Host end: APB registers, link commands, pacing and completion wait.
 * Assumes the device shares this clock, so link inputs need no sync.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tac_defs.svh"
module tac_host #(
    parameter int WW = 24
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    tac_link_if.host link
);
    import tac_pkg::*;

    tac_host_state_t st_q;
    tac_op_t op_q;
    logic use_timer_q, pen_prev_q, dav_prev_q;
    logic [WW-1:0] wait_nom_q, cnt_q;
    logic [15:0] settle_q;
    logic [`TAC_IRQ_W-1:0] irq_st_q, irq_en_q, irq_set, irq_clr;
    logic access, wr_done, mapped, launch, refused, result;
    logic [31:0] rd_mux, ext_wait;
    tac_op_t wr_op;

    if (WW > 24 || WW < 8) begin : g_bad_ww
        $error("tac_host wait width out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, registered answer

    assign access = psel && penable;
    assign wr_done = access && pready && pwrite;
    assign mapped = paddr[1:0] == 2'b00 && paddr <= `TAC_REG_RD_DATA;
    assign wr_op = tac_op_t'(pwdata[`TAC_CMD_OP_MSB:0]);
    assign launch = wr_done && paddr == `TAC_REG_CMD && st_q == HS_IDLE;
    assign refused = wr_done && paddr == `TAC_REG_CMD && st_q != HS_IDLE;
    // Twelve percent stretch for oscillator spread
    assign ext_wait = 32'(wait_nom_q) * 32'(100 + `TAC_OSC_MARGIN_PCT) / 32'd100;

    always_comb begin
        unique case (paddr)
            `TAC_REG_CMD: rd_mux = {23'h0, use_timer_q, 3'h0, op_q};
            `TAC_REG_STATUS: rd_mux = {29'h0, st_q != HS_IDLE,
                                       link.data_available_n, link.pen_touch_irq_n};
            `TAC_REG_IRQ_STATUS: rd_mux = 32'(irq_st_q);
            `TAC_REG_IRQ_ENABLE: rd_mux = 32'(irq_en_q);
            `TAC_REG_WAIT_NOM: rd_mux = 32'(wait_nom_q);
            `TAC_REG_SETTLE: rd_mux = {16'h0, settle_q};
            `TAC_REG_RD_IDX: rd_mux = {28'h0, link.rd_idx};
            `TAC_REG_RD_DATA: rd_mux = {16'h0, link.rd_data};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Answer raised after the first access cycle, dropped after the transfer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= access && !pready;
            if (access && !pready) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr <= !mapped;
            end
        end
    end

    // Software-written settings
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_nom_q <= '0;
            settle_q <= 16'h0000;
            irq_en_q <= '0;
            link.rd_idx <= 4'h0;
        end else if (ce && wr_done) begin
            unique case (paddr)
                `TAC_REG_WAIT_NOM: wait_nom_q <= pwdata[WW-1:0];
                `TAC_REG_SETTLE: settle_q <= pwdata[15:0];
                `TAC_REG_IRQ_ENABLE: irq_en_q <= pwdata[`TAC_IRQ_W-1:0];
                `TAC_REG_RD_IDX: link.rd_idx <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command pacing

    // Conversion requests first drive the panel and wait the settle delay
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= HS_IDLE;
            op_q <= OP_NONE;
            use_timer_q <= 1'b0;
            cnt_q <= '0;
            link.cmd_valid <= 1'b0;
            link.cmd_op <= OP_NONE;
        end else if (ce) begin
            link.cmd_valid <= 1'b0;
            unique case (st_q)
                HS_IDLE: if (launch) begin
                    op_q <= wr_op;
                    use_timer_q <= pwdata[`TAC_CMD_TIMER_BIT];
                    link.cmd_valid <= 1'b1;
                    cnt_q <= WW'(ext_wait);
                    if (wr_op inside {OP_CONV_X, OP_CONV_Y, OP_CONV_Z}) begin
                        link.cmd_op <= tac_op_t'(wr_op - 5'd3);
                        cnt_q <= WW'(settle_q);
                        st_q <= HS_SETTLE;
                    end else begin
                        link.cmd_op <= wr_op;
                        if (!(wr_op inside {OP_NONE, OP_DRIVE_X, OP_DRIVE_Y, OP_DRIVE_Z})) begin
                            st_q <= HS_WAIT;
                        end
                    end
                end
                HS_SETTLE: begin
                    cnt_q <= cnt_q - WW'(1);
                    if (cnt_q == '0) begin
                        link.cmd_valid <= 1'b1;
                        link.cmd_op <= op_q;
                        cnt_q <= WW'(ext_wait);
                        st_q <= HS_WAIT;
                    end
                end
                HS_WAIT: begin
                    if (cnt_q != '0) begin
                        cnt_q <= cnt_q - WW'(1);
                    end
                    if (result) begin
                        st_q <= HS_IDLE;
                    end
                end
                default: st_q <= HS_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts

    // Completion by timer or by the data-available falling edge
    assign result = st_q == HS_WAIT && (use_timer_q ? (cnt_q == '0)
        : (dav_prev_q && !link.data_available_n));
    assign irq_clr = (wr_done && paddr == `TAC_REG_IRQ_CLEAR)
        ? pwdata[`TAC_IRQ_W-1:0] : '0;

    always_comb begin
        irq_set = '0;
        irq_set[`TAC_IRQ_PEN_DOWN] = pen_prev_q && !link.pen_touch_irq_n;
        irq_set[`TAC_IRQ_RESULT] = result;
        irq_set[`TAC_IRQ_REFUSED] = refused;
        irq_set[`TAC_IRQ_PEN_UP] = !pen_prev_q && link.pen_touch_irq_n;
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_st_q <= '0;
            pen_prev_q <= 1'b1;
            dav_prev_q <= 1'b1;
            irq <= 1'b0;
        end else if (ce) begin
            irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
            pen_prev_q <= link.pen_touch_irq_n;
            dav_prev_q <= link.data_available_n;
            irq <= |(irq_st_q & irq_en_q);
        end
    end
endmodule // tac_host
`default_nettype wire

// >>> testbench/tac_link_monitor.sv
/* Checker of the link and the analog controls.
   Assumes one clock; the bench instantiates it. */
`timescale 1ns/1ps
`default_nettype none
module tac_link_monitor (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic touch_sense,
    input wire logic busy,
    input wire logic sampling,
    input wire logic bat1_div_en,
    input wire logic bat2_div_en,
    input wire logic bias_x82,
    input wire logic [3:0] mux_sel,
    input wire logic [3:0] rd_idx,
    input wire logic [15:0] rd_data,
    input wire logic pen_touch_irq_n,
    input wire logic data_available_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////////
    // Two sync flops plus output register
    sequence touch_held;
        touch_sense [*4];
    endsequence
    pen_low_a: assert property (touch_held |-> !pen_touch_irq_n)
        else $error("pen irq not low");
    div_one_a: assert property (bat1_div_en |-> sampling && mux_sel == 4'h6)
        else $error("divider one on");
    div_two_a: assert property (bat2_div_en |-> sampling && mux_sel == 4'h7)
        else $error("divider two on");
    bias_t2_a: assert property (bias_x82 |-> mux_sel == 4'h5)
        else $error("bias on wrong step");
    dav_fall_a: assert property ($fell(data_available_n) |-> $past(busy))
        else $error("done without run");
    take_dav_a: assert property ($rose(busy) |-> ##[0:1] data_available_n)
        else $error("done flag kept");
    samp_busy_a: assert property (sampling |-> busy)
        else $error("idle sampling");
    idx_zero_a: assert property (rd_idx >= 4'hA |=> rd_data == 16'h0)
        else $error("empty index data");
endmodule // tac_link_monitor
`default_nettype wire

// >>> testbench/touch_aux_conversion_sequencer_test.sv
/* Bench: both ends, random measurements over APB.
   Assumes package, interface and designs compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "tac_defs.svh"
module touch_aux_conversion_sequencer_test;
    import tac_pkg::*;
    logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, touch_sense = 0;
    logic ref_on_demand = 1, pready, pslverr, irq, e, sampling, bat1_div_en, bat2_div_en;
    logic bias_x82, busy;
    logic [3:0] mux_sel;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [11:0] conv_data = 12'h000;
    logic [15:0] dly = 16'h0005;
    logic [2:0] avg_log2 = 3'h0;
    int n_mismatch = 0, n_checks = 0, seed = 32'h663a5c9f;
    tac_link_if link ();
    always #5 clk = ~clk;
    // One delay value feeds all three waits
    tac_device tac_device_i (.clk(clk), .arst_n(arst_n), .ce(1'b1), .link(link),
        .touch_sense(touch_sense), .conv_data(conv_data), .res_sel(RES_12),
        .avg_log2(avg_log2), .settle_cyc(dly), .pre_sense_cyc(dly), .ref_delay_cyc(dly),
        .ref_on_demand(ref_on_demand), .conv_clk_div(8'h01), .x_drive(), .y_drive(),
        .z_drive(), .mux_sel(mux_sel), .sampling(sampling), .bat1_div_en(bat1_div_en),
        .bat2_div_en(bat2_div_en), .ref_power(), .bias_x82(bias_x82), .busy(busy));
    tac_host tac_host_i (.clk(clk), .arst_n(arst_n), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .link(link));
    tac_link_monitor tac_link_monitor_i (.clk(clk), .arst_n(arst_n),
        .touch_sense(touch_sense), .busy(busy), .sampling(sampling),
        .bat1_div_en(bat1_div_en), .bat2_div_en(bat2_div_en), .bias_x82(bias_x82),
        .mux_sel(mux_sel), .rd_idx(link.rd_idx), .rd_data(link.rd_data),
        .pen_touch_irq_n(link.pen_touch_irq_n), .data_available_n(link.data_available_n));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, s, x);
        end
    endtask
    // One APB transfer after an idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic end_of_test;
        if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Result slot checked per command; the X slot for the XY and XYZ scans
    function automatic logic [3:0] idx_of(input int op);
        if (op >= 12) return 4'(op - 8);
        if (op == 2 || op == 10) return 4'h1;
        if (op == 3 || op == 11) return 4'h2;
        return 4'h0;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        touch_sense <= 1'b1;
        repeat (6) @(posedge clk);
        apb(1, `TAC_REG_STATUS, 32'h0);
        apb(0, `TAC_REG_STATUS, 32'h0);
        chk(r[0], 1'b0);
        apb(1, `TAC_REG_IRQ_ENABLE, 32'h2);
        apb(1, `TAC_REG_SETTLE, 32'h5);
        apb(1, `TAC_REG_WAIT_NOM, 32'd3000);
        // Each measuring op; battery and auxiliary use the timer
        for (int op = 1; op < 18; op++) begin
            if (op >= 6 && op <= 8) continue;
            conv_data <= 12'($random(seed));
            avg_log2 <= 3'($random(seed) & 1);
            dly <= 16'(3 + ($random(seed) & 7));
            ref_on_demand <= 1'($random(seed));
            apb(1, `TAC_REG_CMD, 32'(op) | (op >= 14 ? 32'h100 : 32'h0));
            if (op == 5) apb(1, `TAC_REG_CMD, 32'(op));
            repeat (20000) if (irq !== 1'b1) @(posedge clk);
            chk(irq, 1'b1);
            apb(0, `TAC_REG_IRQ_STATUS, 32'h0);
            chk(r[2:1], {op == 5, 1'b1});
            apb(1, `TAC_REG_IRQ_CLEAR, 32'hF);
            apb(1, `TAC_REG_RD_IDX, 32'(idx_of(op)));
            apb(0, `TAC_REG_RD_DATA, 32'h0);
            chk(r, {20'h0, conv_data});
        end
        apb(1, `TAC_REG_RD_IDX, 32'hA);
        apb(0, `TAC_REG_RD_DATA, 32'h0);
        chk(r, 32'h0);
        apb(0, 8'h24, 32'h0);
        chk(e, 1'b1);
        touch_sense <= 1'b0;
        repeat (6) @(posedge clk);
        apb(0, `TAC_REG_STATUS, 32'h0);
        chk(r[1:0], 2'b01);
        end_of_test;
    end
    // Far past the longest run
    initial begin
        #1000000;
        n_mismatch++;
        end_of_test;
    end
endmodule // touch_aux_conversion_sequencer_test
`default_nettype wire
